/* File: src/ee_slave.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ee_map.svh"

// Behaviour
// - Start is data falling while clock high; detected by the slave.
// - Watch both lines always; ignore everything until a start. The code watches them only while ce_i is high.
// - Stop is data rising while clock high; ends transfers, returns to standby.
// - Data line changes only while clock is low, except start and stop.
// - Transmitter releases data after eight bits; receiver pulls low on ninth.
// - Acknowledge a start followed by a matching slave address.
// - Once addressed for write, acknowledge every received byte.
// - Read: send byte, release, sample ack; continue on ack, else stop.
// - Top four address bits must equal the fixed device-type code.
// - Next two address bits must equal the two select pin levels.
// - Seventh address bit is the top array bit, joined to word address.
// - Last address bit selects direction: one read, zero write.
// - Byte write: address, word address, data, stop starts internal write.
// - During internal write the inputs are disabled, nothing answered.
// - Page write accepts up to fifteen more bytes, each acknowledged.
// - Write increments only the four low address bits.
// - Beyond sixteen bytes the low bits wrap and overwrite the page.
// - Polling: write address acknowledged only after internal write ends.
// - Counter holds last address plus one; current read returns it.
// - Random read: dummy write of address, repeated start, read address.
// - Sequential read increments all bits and wraps from last to zero.
module ee_slave #(
   parameter logic [3:0] DEV_TYPE = 4'h6, // Arbitrary value
   parameter int WR_CYCLES = `EE_WR_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic link_clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic select_pin_low_i,
   input wire logic select_pin_high_i,
   output logic busy_o
);

   localparam int PW = `EE_PAGE_W;
   localparam int AW = `EE_ADDR_W;

   // ----------------------------------------
   // Input synchronisers and line events
   // ----------------------------------------
   logic busy_sys;
   logic scl_s, sda_s, sel_lo_s, sel_hi_s, ce_l, busy_s;
   logic scl_d_ff, sda_d_ff;
   logic start_c, stop_c, scl_rise, scl_fall;

   ee_sync #(.W(6)) u_link_sync (
      .clk_i(link_clk_i),
      .reset_i(reset_i),
      .d_i({scl_i, sda_i, select_pin_low_i, select_pin_high_i, ce_i, busy_sys}),
      .q_o({scl_s, sda_s, sel_lo_s, sel_hi_s, ce_l, busy_s})
   );

   always_ff @(posedge link_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end
      else if (ce_l)
      begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   assign start_c = ce_l & scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign stop_c = ce_l & scl_s & scl_d_ff & ~sda_d_ff & sda_s;
   assign scl_rise = ce_l & scl_s & ~scl_d_ff;
   assign scl_fall = ce_l & ~scl_s & scl_d_ff;

   // ----------------------------------------
   // Protocol state
   // ----------------------------------------
   ee_pkg::ee_state_t state_ff, nxt_state;
   logic [2:0] bit_cnt_ff;
   logic [7:0] rx_ff, tx_ff, rd_byte;
   logic rx_full_ff, oe_ff, ack_seen_ff, wr_tog_ff, pend_ff;
   logic [AW-1:0] addr_ff;
   logic [`EE_PAGE_BYTES-1:0] pmask_ff;
   logic [7:0] pbuf [`EE_PAGE_BYTES];
   logic [7:0] mem [`EE_MEM_WORDS];
   logic rx_state, byte_in, match, busy_eff, commit, rd_last;

   assign busy_eff = pend_ff | busy_s;
   assign rx_state = state_ff == ee_pkg::st_devadr || state_ff == ee_pkg::st_word
                     || state_ff == ee_pkg::st_wdata;
   assign byte_in = rx_state & scl_fall & rx_full_ff;
   assign match = rx_ff[`EE_TYPE_MSB:`EE_TYPE_LSB] == DEV_TYPE
                  && rx_ff[`EE_SEL_HI_BIT] == sel_hi_s
                  && rx_ff[`EE_SEL_LO_BIT] == sel_lo_s;
   assign commit = stop_c & (|pmask_ff);
   assign rd_last = state_ff == ee_pkg::st_rdata && scl_fall && bit_cnt_ff == `EE_LAST_BIT;
   assign rd_byte = mem[addr_ff];

   always_comb
   begin
      nxt_state = state_ff;
      if (start_c)
         // Busy device behaves as absent, so polling sees no ack
         nxt_state = busy_eff ? ee_pkg::st_idle : ee_pkg::st_devadr;
      else if (stop_c)
         nxt_state = ee_pkg::st_idle;
      else
      begin
         case (state_ff)
            ee_pkg::st_idle:
               nxt_state = ee_pkg::st_idle;
            ee_pkg::st_devadr:
               if (byte_in)
                  nxt_state = match ? ee_pkg::st_adrack : ee_pkg::st_idle;
            ee_pkg::st_adrack:
               if (scl_fall)
                  nxt_state = rx_ff[`EE_RW_BIT] ? ee_pkg::st_rdata : ee_pkg::st_word;
            ee_pkg::st_word:
               if (byte_in)
                  nxt_state = ee_pkg::st_wordack;
            ee_pkg::st_wordack:
               if (scl_fall)
                  nxt_state = ee_pkg::st_wdata;
            ee_pkg::st_wdata:
               if (byte_in)
                  nxt_state = ee_pkg::st_wdack;
            ee_pkg::st_wdack:
               if (scl_fall)
                  nxt_state = ee_pkg::st_wdata;
            ee_pkg::st_rdata:
               if (rd_last)
                  nxt_state = ee_pkg::st_mack;
            ee_pkg::st_mack:
               if (scl_fall)
                  nxt_state = ack_seen_ff ? ee_pkg::st_rdata : ee_pkg::st_idle;
            default:
               nxt_state = ee_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge link_clk_i or posedge reset_i)
   begin
      if (reset_i)
         state_ff <= ee_pkg::st_idle;
      else if (ce_l)
         state_ff <= nxt_state;
   end

   // ----------------------------------------
   // Bit counting and receive shifter
   // ----------------------------------------
   always_ff @(posedge link_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         bit_cnt_ff <= 3'h0;
         rx_ff <= 8'h00;
         rx_full_ff <= 1'b0;
      end
      else if (start_c || stop_c)
      begin
         bit_cnt_ff <= 3'h0;
         rx_full_ff <= 1'b0;
      end
      else if (rx_state && scl_rise)
      begin
         rx_ff <= {rx_ff[6:0], sda_s};
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         rx_full_ff <= bit_cnt_ff == `EE_LAST_BIT;
      end
      else if (byte_in)
         rx_full_ff <= 1'b0;
      else if (state_ff == ee_pkg::st_rdata && scl_fall)
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
   end

   always_ff @(posedge link_clk_i or posedge reset_i)
   begin
      if (reset_i)
         ack_seen_ff <= 1'b0;
      else if (state_ff == ee_pkg::st_mack && scl_rise)
         ack_seen_ff <= ~sda_s;
   end

   // ----------------------------------------
   // Data line drive
   // ----------------------------------------
   // Drive changes other than the release on start or stop follow a clock fall, so no false start or stop
   always_ff @(posedge link_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         oe_ff <= 1'b0;
         tx_ff <= 8'h00;
      end
      else if (start_c || stop_c)
         oe_ff <= 1'b0;
      else if (byte_in)
         oe_ff <= state_ff == ee_pkg::st_devadr ? match : 1'b1;
      else if (scl_fall)
      begin
         case (state_ff)
            ee_pkg::st_adrack:
            begin
               tx_ff <= rd_byte;
               oe_ff <= rx_ff[`EE_RW_BIT] & ~rd_byte[7];
            end
            ee_pkg::st_wordack, ee_pkg::st_wdack:
               oe_ff <= 1'b0;
            ee_pkg::st_rdata:
               if (bit_cnt_ff == `EE_LAST_BIT)
                  oe_ff <= 1'b0;
               else
               begin
                  tx_ff <= {tx_ff[6:0], 1'b0};
                  oe_ff <= ~tx_ff[6];
               end
            ee_pkg::st_mack:
            begin
               tx_ff <= rd_byte;
               oe_ff <= ack_seen_ff & ~rd_byte[7];
            end
            default:
               oe_ff <= 1'b0;
         endcase
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = oe_ff;

   // ----------------------------------------
   // Address counter
   // ----------------------------------------
   always_ff @(posedge link_clk_i or posedge reset_i)
   begin
      if (reset_i)
         addr_ff <= '0;
      else if (byte_in)
      begin
         case (state_ff)
            ee_pkg::st_devadr:
               if (match)
                  addr_ff[AW-1] <= rx_ff[`EE_A8_BIT];
            ee_pkg::st_word:
               addr_ff[7:0] <= rx_ff;
            ee_pkg::st_wdata:
               addr_ff[PW-1:0] <= addr_ff[PW-1:0] + PW'(1);
            default:
               addr_ff <= addr_ff;
         endcase
      end
      else if (rd_last)
         addr_ff <= addr_ff + 9'h001;
   end

   // ----------------------------------------
   // Page buffer and internal write
   // ----------------------------------------
   // Only a stop commits; a repeated start drops a half-done page
   always_ff @(posedge link_clk_i or posedge reset_i)
   begin
      if (reset_i)
         pmask_ff <= '0;
      else if (start_c || stop_c)
         pmask_ff <= '0;
      else if (byte_in && state_ff == ee_pkg::st_wdata)
         pmask_ff[addr_ff[PW-1:0]] <= 1'b1;
   end

   always_ff @(posedge link_clk_i)
   begin
      if (byte_in && state_ff == ee_pkg::st_wdata)
         pbuf[addr_ff[PW-1:0]] <= rx_ff;
      if (commit)
      begin
         for (int i = 0; i < `EE_PAGE_BYTES; i++)
         begin
            if (pmask_ff[i])
               mem[{addr_ff[AW-1:PW], PW'(i)}] <= pbuf[i];
         end
      end
   end

   // Local pending flag covers the crossing delay before busy returns
   always_ff @(posedge link_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wr_tog_ff <= 1'b0;
         pend_ff <= 1'b0;
      end
      else if (commit)
      begin
         wr_tog_ff <= ~wr_tog_ff;
         pend_ff <= 1'b1;
      end
      else if (ce_l && pend_ff && busy_s)
         pend_ff <= 1'b0;
   end

   ee_wr_timer #(.CYCLES(WR_CYCLES)) u_wr_timer (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .req_tog_i(wr_tog_ff),
      .busy_o(busy_sys)
   );

   assign busy_o = busy_sys;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge link_clk_i);
   endclocking
   default disable iff (reset_i);

   a_start_open: assert property (start_c && !busy_eff |=> state_ff == ee_pkg::st_devadr)
      else $error("start not taken");
   a_stop_idle: assert property (stop_c |=> state_ff == ee_pkg::st_idle && !oe_ff)
      else $error("stop did not return to idle");
   a_idle_quiet: assert property (state_ff == ee_pkg::st_idle && !start_c
      |=> state_ff == ee_pkg::st_idle)
      else $error("left idle without start");
   a_sda_edge_low: assert property ($changed(oe_ff) |-> !$past(scl_s) || $past(start_c || stop_c))
      else $error("data drive changed with clock high");
   a_addr_ack: assert property (state_ff == ee_pkg::st_devadr && byte_in && match
      |=> oe_ff && state_ff == ee_pkg::st_adrack)
      else $error("matching address not acknowledged");
   a_addr_nomatch: assert property (state_ff == ee_pkg::st_devadr && byte_in && !match
      |=> !oe_ff && state_ff == ee_pkg::st_idle)
      else $error("mismatch not ignored");
   a_write_ack: assert property (state_ff == ee_pkg::st_wdack
      || state_ff == ee_pkg::st_wordack |-> oe_ff)
      else $error("write byte not acknowledged");
   a_ack_release: assert property (state_ff == ee_pkg::st_wdack && scl_fall |=> !oe_ff)
      else $error("ack not released");
   a_rw_dir: assert property (state_ff == ee_pkg::st_adrack && scl_fall
      |=> (state_ff == ee_pkg::st_rdata) == $past(rx_ff[`EE_RW_BIT]))
      else $error("direction bit ignored");
   a_page_wrap: assert property (state_ff == ee_pkg::st_wdata && byte_in
      |=> addr_ff[AW-1:PW] == $past(addr_ff[AW-1:PW])
      && addr_ff[PW-1:0] == $past(addr_ff[PW-1:0]) + 4'h1)
      else $error("page address step wrong");
   a_read_step: assert property (rd_last |=> addr_ff == $past(addr_ff) + 9'h001 && !oe_ff)
      else $error("read address step wrong");
   a_nack_end: assert property (state_ff == ee_pkg::st_mack && scl_fall && !ack_seen_ff
      |=> !oe_ff && state_ff == ee_pkg::st_idle)
      else $error("read continued without ack");
   a_busy_silent: assert property (pend_ff || busy_s |-> ##1 !oe_ff
      && state_ff != ee_pkg::st_adrack)
      else $error("answered while busy");
   a_busy_seen: assert property (commit ##1 ce_l [*8] |-> ##[1:40] busy_s)
      else $error("internal write never became busy");

   c_byte_write: cover property (commit);
   c_poll_nack: cover property (start_c && busy_eff);
   c_seq_read: cover property (state_ff == ee_pkg::st_mack && scl_fall && ack_seen_ff);
   c_page_full: cover property (byte_in && state_ff == ee_pkg::st_wdata && (&pmask_ff));

endmodule : ee_slave

`default_nettype wire

/* File: include/ee_map.svh */
`ifndef EE_MAP_SVH
`define EE_MAP_SVH

// ----------------------------------------
// Slave address byte fields
// ----------------------------------------
`define EE_TYPE_MSB 7
`define EE_TYPE_LSB 4
`define EE_SEL_HI_BIT 3
`define EE_SEL_LO_BIT 2
`define EE_A8_BIT 1
`define EE_RW_BIT 0

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define EE_ADDR_W 9
`define EE_MEM_WORDS 512
`define EE_PAGE_W 4
`define EE_PAGE_BYTES 16
`define EE_LAST_BIT 3'h7

// ----------------------------------------
// Internal write timing
// ----------------------------------------
`define EE_WR_TIME_US 5000
`define EE_CLK_MHZ 125
`define EE_WR_CYCLES (`EE_WR_TIME_US * `EE_CLK_MHZ)

`endif

/* File: include/ee_pkg.sv */
package ee_pkg;

   // Gray-coded along the write transfer path
   typedef enum logic [3:0] {
      st_idle = 4'h0,
      st_devadr = 4'h1,
      st_adrack = 4'h3,
      st_word = 4'h2,
      st_wordack = 4'h6,
      st_wdata = 4'h7,
      st_wdack = 4'h5,
      st_rdata = 4'h4,
      st_mack = 4'hC
   } ee_state_t;

endpackage : ee_pkg

/* File: src/ee_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module ee_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   // Left free-running so a frozen clock enable cannot block its own sync
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;

endmodule : ee_sync

`default_nettype wire

/* File: src/ee_wr_timer.sv */
`timescale 1ns/10ps
`default_nettype none

module ee_wr_timer #(
   parameter int CYCLES = 625000
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic req_tog_i,
   output logic busy_o
);

   localparam int CW = $clog2(CYCLES + 1);

   logic tog_s;
   logic tog_d_ff;
   logic busy_ff;
   logic [CW-1:0] cnt_ff;
   logic start_c;

   ee_sync #(.W(1)) u_tog_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(req_tog_i),
      .q_o(tog_s)
   );

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         tog_d_ff <= 1'b0;
      else if (ce_i)
         tog_d_ff <= tog_s;
   end

   assign start_c = tog_s ^ tog_d_ff;

   // Busy for exactly CYCLES clocks after each request
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         busy_ff <= 1'b0;
         cnt_ff <= '0;
      end
      else if (ce_i)
      begin
         if (start_c)
         begin
            busy_ff <= 1'b1;
            cnt_ff <= CW'(CYCLES - 1);
         end
         else if (busy_ff && cnt_ff != '0)
            cnt_ff <= cnt_ff - CW'(1);
         else
            busy_ff <= 1'b0;
      end
   end

   assign busy_o = busy_ff;

endmodule : ee_wr_timer

`default_nettype wire

/* File: verif/ee_bus_master.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Two-wire bus master model
// ----------------------------------------
module ee_bus_master (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // Quarter bit; keeps each clock phase well above the slave's sync delay
   localparam int Q = 4;

   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic wq();
      repeat (Q) @(posedge clk_i);
   endtask : wq

   // Also serves as repeated start from clock low
   task automatic start();
      wq();
      sda_o <= 1'b1;
      wq();
      scl_o <= 1'b1;
      wq();
      sda_o <= 1'b0;
      wq();
      scl_o <= 1'b0;
   endtask : start

   task automatic stop();
      wq();
      sda_o <= 1'b0;
      wq();
      scl_o <= 1'b1;
      wq();
      sda_o <= 1'b1;
      wq();
   endtask : stop

   task automatic bit_io(input logic b, output logic s);
      wq();
      sda_o <= b;
      wq();
      scl_o <= 1'b1;
      wq();
      s = sda_i;
      wq();
      scl_o <= 1'b0;
   endtask : bit_io

   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(b[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : send

   task automatic recv(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, b[i]);
      end
      bit_io(~ack, s);
   endtask : recv
endmodule : ee_bus_master

`default_nettype wire

/* File: verif/ee_slave_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module ee_slave_tb_top;
   localparam logic [3:0] TYPE = 4'h6; // Arbitrary value
   localparam int WRC = 200;

   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b0;
   logic sel_lo = 1'b0;
   logic sel_hi = 1'b1;
   logic scl;
   logic sda_m;
   logic sda_oe;
   logic sda_d;
   logic busy;
   logic sda;
   int mismatches = 0;
   int n_compared = 0;
   int busy_len = 0;
   int last_len = 0;

   // ----------------------------------------
   // Clocks, wire, instances
   // ----------------------------------------
   always #4 clk = ~clk;

   initial
   begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end

   // Pull-up: low when either party pulls
   assign sda = sda_m & (~sda_oe | sda_d);

   ee_bus_master master (
      .clk_i(clk),
      .sda_i(sda),
      .scl_o(scl),
      .sda_o(sda_m)
   );

   ee_slave #(
      .DEV_TYPE(TYPE),
      .WR_CYCLES(WRC)
   ) dut (
      .clk_i(clk),
      .reset_i(reset),
      .ce_i(ce),
      .link_clk_i(link_clk),
      .scl_i(scl),
      .sda_i(sda),
      .sda_o(sda_d),
      .sda_oe_o(sda_oe),
      .select_pin_low_i(sel_lo),
      .select_pin_high_i(sel_hi),
      .busy_o(busy)
   );

   // ----------------------------------------
   // Checking helpers
   // ----------------------------------------
   task automatic compare_bit(input string what, input logic exp, input logic got);
      n_compared++;
      if (got !== exp)
      begin
         $display("Error %s expected %0h seen %0h", what, exp, got);
         mismatches++;
      end
   endtask : compare_bit

   task automatic compare_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("Error %s expected %0h seen %0h", what, exp, got);
         mismatches++;
      end
   endtask : compare_byte

   task automatic results();
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results

   function automatic logic [7:0] sa(input logic a8, input logic rw);
      return {TYPE, sel_hi, sel_lo, a8, rw};
   endfunction : sa

   always @(posedge clk)
   begin
      if (busy === 1'b1)
         busy_len++;
      else if (busy_len != 0)
      begin
         last_len = busy_len;
         busy_len = 0;
      end
   end

   // Device may only move the line while the clock is low
   always @(sda_oe)
   begin
      if (reset === 1'b0)
         compare_bit("scl at sda change", 1'b0, scl);
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_mismatch();
      logic [7:0] bad [3];
      logic ack;
      bad = '{{TYPE ^ 4'h8, sel_hi, sel_lo, 2'h0}, {TYPE, ~sel_hi, sel_lo, 2'h0},
              {TYPE, sel_hi, ~sel_lo, 2'h0}};
      for (int i = 0; i < 3; i++)
      begin
         master.start();
         master.send(bad[i], ack);
         compare_bit("foreign address ack", 1'b0, ack);
         master.send(8'h00, ack);
         compare_bit("ignored byte ack", 1'b0, ack);
         master.stop();
      end
   endtask : t_mismatch

   task automatic t_write(input logic a8, input logic [7:0] word, input int n,
                          input logic [7:0] base);
      logic ack;
      master.start();
      master.send(sa(a8, 1'b0), ack);
      compare_bit("write address ack", 1'b1, ack);
      master.send(word, ack);
      compare_bit("word address ack", 1'b1, ack);
      for (int k = 0; k < n; k++)
      begin
         master.send(base + 8'(k), ack);
         compare_bit("data ack", 1'b1, ack);
      end
      master.stop();
   endtask : t_write

   task automatic t_poll();
      logic ack;
      int polls;
      polls = 0;
      ack = 1'b0;
      while (ack !== 1'b1 && polls < 12)
      begin
         master.start();
         master.send(sa(1'b0, 1'b0), ack);
         master.stop();
         if (polls == 0)
            compare_bit("poll ack while busy", 1'b0, ack);
         polls++;
      end
      compare_bit("poll ack after write", 1'b1, ack);
      compare_bit("busy at poll ack", 1'b0, busy);
      compare_bit("busy length", 1'b1, last_len == WRC);
   endtask : t_poll

   task automatic t_read(input logic a8, input logic [7:0] word, input logic [7:0] exp [$]);
      logic ack;
      logic [7:0] b;
      master.start();
      master.send(sa(a8, 1'b0), ack);
      master.send(word, ack);
      master.start();
      master.send(sa(a8, 1'b1), ack);
      compare_bit("read address ack", 1'b1, ack);
      for (int i = 0; i < exp.size(); i++)
      begin
         master.recv(i < exp.size() - 1, b);
         compare_byte("read data", exp[i], b);
      end
      master.stop();
   endtask : t_read

   task automatic t_current(input logic [7:0] exp);
      logic ack;
      logic [7:0] b;
      master.start();
      master.send(sa(1'b0, 1'b1), ack);
      compare_bit("current read ack", 1'b1, ack);
      master.recv(1'b0, b);
      compare_byte("current read data", exp, b);
      master.stop();
   endtask : t_current

   // Frozen clock enable: a matching address must go unanswered
   task automatic t_frozen();
      logic ack;
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      master.start();
      master.send(sa(1'b0, 1'b1), ack);
      compare_bit("frozen address ack", 1'b0, ack);
      master.stop();
      ce <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : t_frozen

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      ce <= 1'b1;
      repeat (8) @(posedge clk);
      t_mismatch();
      // Seventeen bytes from 0x0E: last one lands on 0x0E again
      t_write(1'b0, 8'h0E, 17, 8'hA0);
      t_poll();
      t_write(1'b1, 8'hFF, 1, 8'h3C);
      t_poll();
      t_read(1'b0, 8'h0E, {8'hB0, 8'hA1});
      t_read(1'b1, 8'hFF, {8'h3C, 8'hA2, 8'hA3});
      t_frozen();
      // New strap levels must be matched by the next address
      sel_lo <= 1'b1;
      sel_hi <= 1'b0;
      repeat (4) @(posedge clk);
      t_current(8'hA4);
      results();
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      $display("Error watchdog expected 0 seen 1");
      mismatches++;
      results();
   end
endmodule : ee_slave_tb_top

`default_nettype wire
